// ==== bench/abbp_cmd_ctrl_sva.sv ====
// Purpose: timing checks on the command interpreter ports
// Assumes: one clock domain, async active-low reset
// Notes: bound to every abbp_cmd_ctrl instance
`timescale 1ns/1ps
`include "abbp_defs.svh"
module abbp_cmd_ctrl_chk
  import abbp_pkg::*;
#(
  parameter int UNIT_CYC = 4,
  parameter int MAX_BLOCK = 8
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Command side
  input wire logic CE,
  input wire logic CMD_STB,
  input wire abbp_pkg::abbp_cmd_t CMD_IN,
  input wire logic SOFT_RST,
  // Status side
  input wire logic BSY,
  input wire logic DRQ,
  input wire logic DMARQ,
  input wire logic INTRQ,
  input wire logic ERR,
  input wire logic [7:0] ERR_CODE,
  input wire logic MULT_EN,
  input wire logic [7:0] BLOCK_CNT,
  input wire logic SPINDLE_ON,
  input wire logic HEADS_PARKED,
  input wire logic [1:0] PWR_STATE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  logic tk;
  logic [7:0] op;
  logic [7:0] cn;
  assign tk = CE && CMD_STB && !BSY && !DRQ && !DMARQ;
  assign op = CMD_IN.code;
  assign cn = CMD_IN.count;
  // =====
  // Sequences
  sequence setm_s; tk && op == `ABBP_CMD_SET_MULT; endsequence
  sequence setm_end_s; BSY ##2 (!BSY && INTRQ); endsequence
  sequence buf_resp_s; BSY ##1 (DRQ && INTRQ && !BSY); endsequence
  // =====
  // Assertions
  setm_done_a: assert property (setm_s |=> setm_end_s)
    else $error("set-multiple busy window wrong");
  setm_ok_a: assert property (setm_s ##0 (cn != 8'h00 && cn <= 8'(MAX_BLOCK))
    |-> ##3 (MULT_EN && BLOCK_CNT == $past(cn, 3))) else $error("block size not stored");
  setm_bad_a: assert property (setm_s ##0 (cn > 8'(MAX_BLOCK))
    |-> ##3 (!MULT_EN && ERR && ERR_CODE == `ABBP_ERR_ABORT)) else $error("bad block size kept");
  setm_zero_a: assert property (setm_s ##0 (cn == 8'h00) |-> ##3 !MULT_EN)
    else $error("zero count left multiple on");
  mult_off_a: assert property ((tk && (op == `ABBP_CMD_RD_MULT || op == `ABBP_CMD_WR_MULT)
    && !MULT_EN) |-> ##[1:4] (ERR && ERR_CODE == `ABBP_ERR_ABORT)) else $error("disabled multiple ran");
  buf_rd_a: assert property ((tk && op == `ABBP_CMD_RD_BUF) |=> buf_resp_s)
    else $error("buffer read handshake wrong");
  buf_wr_a: assert property ((tk && op == `ABBP_CMD_WR_BUF) |=> buf_resp_s)
    else $error("buffer write handshake wrong");
  stby_imm_a: assert property ((tk && op == `ABBP_CMD_STBY_IMM)
    |-> ##[1:4] (PWR_STATE == 2'h1 && !SPINDLE_ON && HEADS_PARKED)) else $error("standby not entered");
  sleep_in_a: assert property ((tk && op == `ABBP_CMD_SLEEP) |-> ##[1:4] (PWR_STATE == 2'h2))
    else $error("sleep not entered");
  soft_rst_a: assert property (SOFT_RST |-> ##[1:2] !MULT_EN)
    else $error("reset left multiple on");
endmodule : abbp_cmd_ctrl_chk

bind abbp_cmd_ctrl abbp_cmd_ctrl_chk #(.UNIT_CYC(UNIT_CYC), .MAX_BLOCK(MAX_BLOCK)) abbp_cmd_ctrl_chk_inst (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .CE(CE), .CMD_STB(CMD_STB), .CMD_IN(CMD_IN), .SOFT_RST(SOFT_RST),
  .BSY(BSY), .DRQ(DRQ), .DMARQ(DMARQ), .INTRQ(INTRQ), .ERR(ERR), .ERR_CODE(ERR_CODE), .MULT_EN(MULT_EN),
  .BLOCK_CNT(BLOCK_CNT), .SPINDLE_ON(SPINDLE_ON), .HEADS_PARKED(HEADS_PARKED), .PWR_STATE(PWR_STATE));

// ==== bench/abbp_host_model.sv ====
// Purpose: host adapter moving PIO words and DMA acknowledges
// Assumes: drives 10 ns after the rising edge
// Notes: slow mode spaces words and delays DMA acknowledge
`timescale 1ns/1ps
module abbp_host_model (
  // Clock
  input wire logic clk,
  // Device requests
  input wire logic drq,
  input wire logic dmarq,
  input wire logic slow,
  // Host answers
  output logic pio_ack,
  output logic dmack,
  output int words
);
  int gap = 0;
  logic fresh = 1'b1;
  logic nxt;
  logic dmarq_q = 1'b0;
  initial begin
    pio_ack = 1'b0;
    dmack = 1'b0;
    words = 0;
  end
  always @(posedge clk) begin
    #10;
    nxt = 1'b0;
    if (!drq) begin
      fresh = 1'b1;
    end else begin
      if (fresh) words = 0;
      fresh = 1'b0;
      if (gap > 0) gap--;
      else if (words < 256) begin
        nxt = 1'b1;
        words++;
        gap = slow ? 2 : 0;
      end
    end
    pio_ack = nxt;
    dmack = slow ? (dmarq && dmarq_q) : dmarq;
    dmarq_q = dmarq;
  end
endmodule : abbp_host_model

// ==== bench/tb.sv ====
// Purpose: directed test of the command interpreter
// Assumes: countdown unit shortened to 4 cycles
// Notes: inputs change 10 ns after the rising edge
`timescale 1ns/1ps
`include "abbp_defs.svh"
module tb;
  import abbp_pkg::*;
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
  logic clk_sys = 1'b0, resetn = 1'b0, cmd_stb = 1'b0, soft_rst = 1'b0, common_access_method_option = 1'b0;
  logic m_rdy = 1'b0, m_err = 1'b0, m_done = 1'b0, slow = 1'b0, pio_ack, dmack, intrq_q = 1'b0;
  abbp_cmd_t cmd_in = '0;
  logic bsy, drq, dmarq, intrq, err, sc_we, mult_en, spin, park, ok;
  logic m_go, ce = 1'b1;
  logic [7:0] err_code, sc_out, blk;
  logic [1:0] pwr;
  logic [7:0] sm [5] = '{8'h01, 8'h08, 8'h09, 8'h05, 8'h00};
  int words, n_mismatch = 0, checked = 0, irq_n = 0, irq0 = 0, go_n = 0, go0 = 0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    intrq_q <= intrq;
    if (intrq && !intrq_q) irq_n <= irq_n + 1;
    if (m_go) go_n <= go_n + 1;
  end
  abbp_cmd_ctrl #(.UNIT_CYC(4)) abbp_cmd_ctrl_inst (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce),
    .CMD_STB(cmd_stb), .CMD_IN(cmd_in), .SOFT_RST(soft_rst), .CAM_OPTION(common_access_method_option), .PIO_ACK(pio_ack),
    .DMACK(dmack), .MEDIA_READY(m_rdy), .MEDIA_ERR(m_err), .MEDIA_DONE(m_done), .BSY(bsy), .DRQ(drq),
    .DMARQ(dmarq), .INTRQ(intrq), .ERR(err), .ERR_CODE(err_code), .SECT_CNT_OUT(sc_out), .SECT_CNT_WE(sc_we),
    .MULT_EN(mult_en), .BLOCK_CNT(blk), .MEDIA_GO(m_go), .SPINDLE_ON(spin), .HEADS_PARKED(park), .PWR_STATE(pwr));
  abbp_host_model abbp_host_model_inst (.clk(clk_sys), .drq(drq), .dmarq(dmarq), .slow(slow),
    .pio_ack(pio_ack), .dmack(dmack), .words(words));
  // =====
  // Access tasks
  task automatic complete_run();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : step
  function automatic logic cond(input int s);
    case (s)
      0: return !bsy && !drq;
      1: return dmarq;
      2: return sc_we;
      3: return pwr == 2'h0;
      default: return pwr == 2'h1;
    endcase
  endfunction : cond
  task automatic wait_until(input int s, input int lim);
    int i;
    i = 0;
    while (cond(s) !== 1'b1 && i < lim) begin
      step(1);
      i++;
    end
    if (cond(s) !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, s, lim);
      complete_run();
    end
  endtask : wait_until
  task automatic cmd(input logic [7:0] c, input logic [7:0] n);
    wait_until(0, 50);
    cmd_in = {c, n};
    cmd_stb = 1'b1;
    step(1);
    cmd_stb = 1'b0;
    irq0 = irq_n;
  endtask : cmd
  // =====
  // Tests
  initial begin
    step(6);
    resetn = 1'b1;
    step(1);
    `CHK({mult_en, spin, pwr}, 4'b0100)
    $display("test reset done");
    foreach (sm[i]) begin
      cmd(`ABBP_CMD_SET_MULT, sm[i]);
      `CHK(bsy, 1'b1)
      step(2);
      ok = sm[i] != 8'h00 && sm[i] <= `ABBP_BLK_MAX;
      `CHK(bsy, 1'b0)
      `CHK(mult_en, ok)
      if (ok) `CHK(blk, sm[i])
      if (sm[i] != 8'h00) `CHK(err, !ok)
    end
    foreach (sm[i]) if (i < 2) begin
      cmd(i ? `ABBP_CMD_WR_MULT : `ABBP_CMD_RD_MULT, 8'h02);
      wait_until(0, 20);
      `CHK({err, err_code}, {1'b1, `ABBP_ERR_ABORT})
    end
    $display("test multiple done");
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      cmd(k ? `ABBP_CMD_WR_BUF : `ABBP_CMD_RD_BUF, 8'h00);
      `CHK(bsy, 1'b1)
      step(1);
      `CHK({drq, intrq, bsy}, 3'b110)
      wait_until(0, 2000);
      `CHK(words, 256)
    end
    $display("test buffer done");
    m_rdy = 1'b1;
    for (int k = 0; k < 4; k++) begin
      slow = k[0];
      go0 = go_n;
      cmd(k[0] ? `ABBP_CMD_WR_DMA : `ABBP_CMD_RD_DMA, 8'h02);
      wait_until(1, 100);
      `CHK(dmarq, 1'b1)
      step(4);
      m_err = k[1];
      m_done = !k[1];
      wait_until(0, 100);
      step(2);
      `CHK({dmarq, err}, {1'b0, k[1]})
      `CHK(irq_n - irq0, 1)
      `CHK(go_n - go0, 1)
      {m_err, m_done} = 2'b00;
      step(2);
    end
    m_rdy = 1'b0;
    $display("test dma done");
    cmd(`ABBP_CMD_STBY_IMM, 8'h00);
    step(3);
    `CHK({pwr, spin, park}, 4'b0101)
    cmd(`ABBP_CMD_CHK_PWR, 8'h00);
    wait_until(2, 20);
    `CHK(sc_out, `ABBP_PWR_STBY_CODE)
    cmd(`ABBP_CMD_IDLE_TMR, 8'h00);
    step(3);
    `CHK(pwr, 2'h0)
    cmd(`ABBP_CMD_CHK_PWR, 8'h00);
    wait_until(2, 20);
    `CHK(sc_out, `ABBP_PWR_IDLE_CODE)
    cmd(`ABBP_CMD_IDLE_TMR, `ABBP_APD_MIN);
    step(40);
    `CHK(pwr, 2'h0)
    wait_until(4, 30);
    `CHK({spin, park}, 2'b01)
    cmd(`ABBP_CMD_IDLE_IMM, 8'h00);
    `CHK(pwr, 2'h1)
    cmd(`ABBP_CMD_CHK_PWR, 8'h00);
    wait_until(2, 20);
    `CHK(sc_out, `ABBP_PWR_STBY_CODE)
    wait_until(3, 20);
    `CHK({pwr, spin, park}, 4'b0010)
    common_access_method_option = 1'b1;
    cmd(`ABBP_CMD_IDLE_TMR, `ABBP_APD_MIN);
    step(60);
    `CHK(pwr, 2'h0)
    common_access_method_option = 1'b0;
    cmd(`ABBP_CMD_IDLE_TMR, 8'h00);
    cmd(`ABBP_CMD_STBY_TMR, 8'h00);
    step(3);
    `CHK(pwr, 2'h1)
    $display("test power done");
    ce = 1'b0;
    cmd(`ABBP_CMD_SET_MULT, 8'h03);
    step(2);
    `CHK({bsy, mult_en}, 2'b00)
    ce = 1'b1;
    cmd(`ABBP_CMD_SET_MULT, 8'h03);
    step(2);
    `CHK({mult_en, blk}, {1'b1, 8'h03})
    cmd(`ABBP_CMD_SLEEP, 8'h00);
    step(3);
    `CHK(pwr, 2'h2)
    cmd(`ABBP_CMD_RD_DMA, 8'h01);
    wait_until(0, 20);
    `CHK(err, 1'b1)
    soft_rst = 1'b1;
    step(1);
    soft_rst = 1'b0;
    step(2);
    `CHK({pwr, mult_en}, 3'b000)
    $display("test sleep done");
    complete_run();
  end
endmodule : tb

// ==== hw/abbp_apd_timer.sv ====
// Purpose: auto power-down countdown
// Assumes: reload and arm come from the main interpreter
// Notes: counts units of UNIT_CYC cycles
`timescale 1ns/1ps
`include "abbp_defs.svh"
module abbp_apd_timer #(
  parameter int UNIT_CYC = `ABBP_APD_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic arm,
  input wire logic reload,
  input wire logic [7:0] load_val,
  output logic tick,
  output logic expire
);
  initial begin
    if (UNIT_CYC < 1) $error("UNIT_CYC must be at least one");
  end
  logic [31:0] pre_q;
  logic [7:0] cnt_q;
  // ==========================================
  // Unit prescaler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 32'h0;
    end else if (ce) begin
      if (reload || !arm || pre_q == 32'(UNIT_CYC - 1)) pre_q <= 32'h0;
      else pre_q <= pre_q + 32'h1;
    end
  end
  // ==========================================
  // Countdown; expiry pulses once at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h0;
      tick <= 1'b0;
      expire <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      expire <= 1'b0;
      if (reload || !arm) begin
        cnt_q <= load_val;
      end else if (pre_q == 32'(UNIT_CYC - 1) && cnt_q != 8'h0) begin
        cnt_q <= cnt_q - 8'h1;
        tick <= 1'b1;
        if (cnt_q == 8'h1) expire <= 1'b1;
      end
    end
  end
endmodule : abbp_apd_timer

// ==== hw/abbp_cmd_ctrl.sv ====
// Purpose: set-multiple, buffer, DMA and power command handling
// Assumes: task-file writes arrive as a one-cycle strobe on the same clock
// Notes: media engine and buffer memory sit outside; this block sequences them
`timescale 1ns/1ps
`include "abbp_defs.svh"
module abbp_cmd_ctrl
  import abbp_pkg::*;
#(
  parameter int UNIT_CYC = `ABBP_APD_UNIT_CYC,
  parameter int MAX_BLOCK = 8
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CE,
  // Command strobe from task file
  input wire logic CMD_STB,
  input wire abbp_pkg::abbp_cmd_t CMD_IN,
  input wire logic SOFT_RST,
  input wire logic CAM_OPTION,
  // Host data handshake
  input wire logic PIO_ACK,
  input wire logic DMACK,
  // Media engine
  input wire logic MEDIA_READY,
  input wire logic MEDIA_ERR,
  input wire logic MEDIA_DONE,
  // Status out
  output logic BSY,
  output logic DRQ,
  output logic DMARQ,
  output logic INTRQ,
  output logic ERR,
  output logic [7:0] ERR_CODE,
  output logic [7:0] SECT_CNT_OUT,
  output logic SECT_CNT_WE,
  output logic MULT_EN,
  output logic [7:0] BLOCK_CNT,
  output logic MEDIA_GO,
  output logic SPINDLE_ON,
  output logic HEADS_PARKED,
  output logic [1:0] PWR_STATE
);
  import abbp_pkg::*;

  initial begin
    if (MAX_BLOCK < 1 || MAX_BLOCK > 8) $error("MAX_BLOCK must lie in 1..8");
  end

  typedef enum logic [2:0] {ABBP_S_IDLE, ABBP_S_SETM, ABBP_S_PREP, ABBP_S_PIO,
                            ABBP_S_DMA, ABBP_S_WAKE, ABBP_S_DONE} abbp_seq_t;

  // ==========================================
  // Input synchronisers for off-domain levels
  logic [1:0] mrdy_s, merr_s, mdone_s, cam_s;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mrdy_s <= 2'h0;
      merr_s <= 2'h0;
      mdone_s <= 2'h0;
      cam_s <= 2'h0;
    end else if (CE) begin
      mrdy_s <= {mrdy_s[0], MEDIA_READY};
      merr_s <= {merr_s[0], MEDIA_ERR};
      mdone_s <= {mdone_s[0], MEDIA_DONE};
      cam_s <= {cam_s[0], CAM_OPTION};
    end
  end
  logic media_rdy, media_err, media_done;
  assign media_rdy = mrdy_s[1];
  assign media_err = merr_s[1];
  assign media_done = mdone_s[1];

  // ==========================================
  // Command decode
  logic [7:0] code, cnt;
  logic is_mult, is_dma, is_buf, is_media, seq_free;
  abbp_seq_t seq_q;
  abbp_pwr_t pwr_q;
  assign code = CMD_IN.code;
  assign cnt = CMD_IN.count;
  assign is_mult = (code == `ABBP_CMD_RD_MULT) || (code == `ABBP_CMD_WR_MULT);
  assign is_dma = (code == `ABBP_CMD_RD_DMA) || (code == `ABBP_CMD_WR_DMA);
  assign is_buf = (code == `ABBP_CMD_RD_BUF) || (code == `ABBP_CMD_WR_BUF);
  assign is_media = is_mult || is_dma;
  assign seq_free = (seq_q == ABBP_S_IDLE);
  logic take;
  assign take = CE && CMD_STB && seq_free;

  // ==========================================
  // Multiple-mode setting
  logic blk_ok;
  assign blk_ok = (cnt >= `ABBP_BLK_MIN) && (cnt <= 8'(MAX_BLOCK));
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      MULT_EN <= 1'b0;
      BLOCK_CNT <= 8'h0;
    end else if (CE) begin
      if (SOFT_RST) begin
        MULT_EN <= 1'b0;
        BLOCK_CNT <= 8'h0;
      end else if (take && code == `ABBP_CMD_SET_MULT) begin
        if (blk_ok) begin
          MULT_EN <= 1'b1;
          BLOCK_CNT <= cnt;
        end else begin
          MULT_EN <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // Command sequencer
  logic rd_dir_q, dma_q;
  logic [8:0] words_q;
  logic pend_err_q;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      seq_q <= ABBP_S_IDLE;
      BSY <= 1'b0;
      DRQ <= 1'b0;
      DMARQ <= 1'b0;
      INTRQ <= 1'b0;
      ERR <= 1'b0;
      ERR_CODE <= 8'h0;
      MEDIA_GO <= 1'b0;
      rd_dir_q <= 1'b0;
      dma_q <= 1'b0;
      words_q <= 9'h0;
      pend_err_q <= 1'b0;
    end else if (CE) begin
      MEDIA_GO <= 1'b0;
      if (SOFT_RST) begin
        seq_q <= ABBP_S_IDLE;
        BSY <= 1'b0;
        DRQ <= 1'b0;
        DMARQ <= 1'b0;
        INTRQ <= 1'b0;
        ERR <= 1'b0;
      end else begin
        if (CMD_STB) INTRQ <= 1'b0;
        case (seq_q)
          ABBP_S_IDLE: begin
            if (take) begin
              ERR <= 1'b0;
              ERR_CODE <= 8'h0;
              rd_dir_q <= (code == `ABBP_CMD_RD_BUF) || (code == `ABBP_CMD_RD_DMA) ||
                          (code == `ABBP_CMD_RD_MULT);
              dma_q <= is_dma;
              BSY <= 1'b1;
              if (code == `ABBP_CMD_SET_MULT) begin
                seq_q <= ABBP_S_SETM;
              end else if ((is_mult && !MULT_EN) || (is_media && pwr_q == ABBP_PWR_SLEEP)) begin
                pend_err_q <= 1'b1;
                seq_q <= ABBP_S_DONE;
              end else if (is_buf) begin
                seq_q <= ABBP_S_PREP;
              end else if (is_media) begin
                seq_q <= ABBP_S_WAKE;
              end else begin
                pend_err_q <= 1'b0;
                seq_q <= ABBP_S_DONE;
              end
            end
          end
          ABBP_S_SETM: begin
            pend_err_q <= (cnt != 8'h0) && !blk_ok;
            seq_q <= ABBP_S_DONE;
          end
          ABBP_S_PREP: begin
            words_q <= `ABBP_BUF_WORDS;
            DRQ <= 1'b1;
            BSY <= 1'b0;
            INTRQ <= 1'b1;
            seq_q <= ABBP_S_PIO;
          end
          ABBP_S_PIO: begin
            if (PIO_ACK) begin
              words_q <= words_q - 9'h1;
              if (words_q == 9'h1) begin
                DRQ <= 1'b0;
                seq_q <= ABBP_S_IDLE;
              end
            end
          end
          ABBP_S_WAKE: begin
            if (media_rdy) begin
              MEDIA_GO <= 1'b1;
              if (dma_q) begin
                seq_q <= ABBP_S_DMA;
              end else begin
                // Sector transfer of multiple commands is handled elsewhere
                pend_err_q <= 1'b0;
                seq_q <= ABBP_S_DONE;
              end
            end
          end
          ABBP_S_DMA: begin
            DMARQ <= !(media_err || media_done) && !DMACK;
            if (media_err) begin
              DMARQ <= 1'b0;
              pend_err_q <= 1'b1;
              seq_q <= ABBP_S_DONE;
            end else if (media_done) begin
              DMARQ <= 1'b0;
              pend_err_q <= 1'b0;
              seq_q <= ABBP_S_DONE;
            end
          end
          ABBP_S_DONE: begin
            BSY <= 1'b0;
            INTRQ <= 1'b1;
            ERR <= pend_err_q;
            ERR_CODE <= pend_err_q ? `ABBP_ERR_ABORT : 8'h0;
            seq_q <= ABBP_S_IDLE;
          end
          default: seq_q <= ABBP_S_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // Power management
  logic apd_arm_q, apd_stby_sel_q, idle_pend_q;
  logic [7:0] apd_val_q;
  logic apd_tick, apd_expire, reload;
  assign reload = take && (is_media || is_buf || code == `ABBP_CMD_IDLE_IMM);
  abbp_apd_timer #(.UNIT_CYC(UNIT_CYC)) u_apd (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .ce(CE),
    .arm(apd_arm_q || idle_pend_q),
    .reload(reload || (take && (code == `ABBP_CMD_STBY_TMR || code == `ABBP_CMD_IDLE_TMR))),
    .load_val((take && (code == `ABBP_CMD_STBY_TMR || code == `ABBP_CMD_IDLE_TMR)) ? cnt : apd_val_q),
    .tick(apd_tick),
    .expire(apd_expire)
  );

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pwr_q <= ABBP_PWR_IDLE;
      apd_arm_q <= 1'b0;
      apd_stby_sel_q <= 1'b0;
      apd_val_q <= 8'h0;
      idle_pend_q <= 1'b0;
      SECT_CNT_OUT <= 8'h0;
      SECT_CNT_WE <= 1'b0;
    end else if (CE) begin
      SECT_CNT_WE <= 1'b0;
      if (SOFT_RST) begin
        if (pwr_q == ABBP_PWR_SLEEP) pwr_q <= ABBP_PWR_IDLE;
      end else if (take) begin
        case (code)
          `ABBP_CMD_STBY_IMM: pwr_q <= ABBP_PWR_STBY;
          `ABBP_CMD_IDLE_IMM: idle_pend_q <= 1'b1;
          `ABBP_CMD_STBY_TMR: begin
            pwr_q <= ABBP_PWR_STBY;
            apd_stby_sel_q <= 1'b1;
            apd_val_q <= cnt;
            apd_arm_q <= (cnt != 8'h0);
          end
          `ABBP_CMD_IDLE_TMR: begin
            pwr_q <= ABBP_PWR_IDLE;
            apd_stby_sel_q <= 1'b0;
            apd_val_q <= cnt;
            apd_arm_q <= (cnt != 8'h0);
          end
          `ABBP_CMD_CHK_PWR: begin
            SECT_CNT_OUT <= (pwr_q == ABBP_PWR_IDLE && !idle_pend_q) ? `ABBP_PWR_IDLE_CODE
                                                                    : `ABBP_PWR_STBY_CODE;
            SECT_CNT_WE <= 1'b1;
          end
          `ABBP_CMD_SLEEP: pwr_q <= ABBP_PWR_SLEEP;
          default: begin
            if (is_media && pwr_q == ABBP_PWR_STBY) pwr_q <= ABBP_PWR_IDLE;
          end
        endcase
      end else begin
        if (idle_pend_q && apd_tick) begin
          idle_pend_q <= 1'b0;
          pwr_q <= ABBP_PWR_IDLE;
        end
        if (apd_expire && apd_arm_q && pwr_q != ABBP_PWR_SLEEP && seq_free) begin
          if (apd_stby_sel_q || !cam_s[1]) pwr_q <= ABBP_PWR_STBY;
          else pwr_q <= ABBP_PWR_IDLE;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      SPINDLE_ON <= 1'b1;
      HEADS_PARKED <= 1'b0;
      PWR_STATE <= 2'h0;
    end else if (CE) begin
      SPINDLE_ON <= (pwr_q == ABBP_PWR_IDLE);
      HEADS_PARKED <= (pwr_q != ABBP_PWR_IDLE);
      PWR_STATE <= pwr_q;
    end
  end
endmodule : abbp_cmd_ctrl

// ==== hw/abbp_defs.svh ====
// Purpose: constants for the command interpreter
// Assumes: 10 MHz system clock
// Notes: all figures as named macros
`ifndef ABBP_DEFS_SVH
`define ABBP_DEFS_SVH
`define ABBP_CMD_RD_MULT 8'hc4
`define ABBP_CMD_WR_MULT 8'hc5
`define ABBP_CMD_SET_MULT 8'hc6
`define ABBP_CMD_RD_DMA 8'hc8
`define ABBP_CMD_WR_DMA 8'hca
`define ABBP_CMD_RD_BUF 8'he4
`define ABBP_CMD_WR_BUF 8'he8
`define ABBP_CMD_STBY_IMM 8'he0
`define ABBP_CMD_IDLE_IMM 8'he1
`define ABBP_CMD_STBY_TMR 8'he2
`define ABBP_CMD_IDLE_TMR 8'he3
`define ABBP_CMD_CHK_PWR 8'he5
`define ABBP_CMD_SLEEP 8'he6
`define ABBP_BLK_MIN 8'h01
`define ABBP_BLK_MAX 8'h08
`define ABBP_APD_MIN 8'h0c
`define ABBP_PWR_IDLE_CODE 8'hff
`define ABBP_PWR_STBY_CODE 8'h00
`define ABBP_BUF_WORDS 9'h100
`define ABBP_ERR_ABORT 8'h04
`define ABBP_APD_UNIT_S 5
`define ABBP_CLK_HZ 10000000
`define ABBP_APD_UNIT_CYC (`ABBP_APD_UNIT_S * `ABBP_CLK_HZ)
`endif

// ==== hw/abbp_pkg.sv ====
// Purpose: types for the command interpreter
// Assumes: nothing
// Notes: power states and command carrier
package abbp_pkg;
  typedef enum logic [1:0] {ABBP_PWR_IDLE, ABBP_PWR_STBY, ABBP_PWR_SLEEP} abbp_pwr_t;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] count;
  } abbp_cmd_t;
endpackage : abbp_pkg
